// File: inc/rsc_defs.svh
/*
  constants of the reset and standby controller: timing counts, reset
  values and port widths.
  assumes it is included by bare name by the package and the design files.
*/
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ==========================================================
// timing
`define RSC_WAKE_CYCLES 16384
`define RSC_CNT_W       15

// ==========================================================
// reset values
`define RSC_TMR0_PRESET 12'hFFC
`define RSC_NIB_HIGH    4'hF
`define RSC_NIB_LOW     4'h0
`define RSC_P3_RESET    3'h7

// ==========================================================
// synchronised pin vector layout
`define RSC_PIN_W       13

`endif

// File: inc/rsc_pkg.sv
/*
  types of the reset and standby controller.
  assumes rsc_defs.svh is on the include path.
*/
`include "rsc_defs.svh"

package rsc_pkg;

  // ==========================================================
  // controller state, one-hot
  typedef enum logic [2:0] {
    RSC_RUN     = 3'b001,  // core executing
    RSC_STANDBY = 3'b010,  // standby, clock to core held
    RSC_WAKE    = 3'b100   // wake-up wait after standby
  } rsc_state_t;

  // ==========================================================
  // port select for core reads and writes
  typedef enum logic [1:0] {
    RSC_SEL_ZERO  = 2'h0,
    RSC_SEL_ONE   = 2'h1,
    RSC_SEL_THREE = 2'h2,
    RSC_SEL_EIGHT = 2'h3
  } rsc_sel_t;

  // ==========================================================
  // pin inputs as one bundle (synchronised together)
  typedef struct packed {
    logic       init_n;     // chip init pin, low active
    logic       standby;    // standby control pin
    logic [2:0] three;      // port three general inputs
    logic [3:0] one;        // port one pins
    logic [3:0] zero;       // port zero pins
  } rsc_pins_t;

  // ==========================================================
  // core port access request
  typedef struct packed {
    logic       wr;         // write strobe
    rsc_sel_t   sel;        // port selected
    logic [3:0] data;       // write data
  } rsc_req_t;

endpackage : rsc_pkg

// File: hdl/rsc_sync2.sv
/*
  two flip-flop synchroniser for a vector of independent levels.
  assumes each bit is a slow level; no bus coherence is given.
*/
module rsc_sync2
  import rsc_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async levels in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;  // first stage, read only by second
  logic [W-1:0] q_ff;     // second stage

  // ==========================================================
  // two stages; reset to zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : rsc_sync2

// File: hdl/rsc_ctrl.sv
/*
  reset and standby controller of a four bit microcontroller core.
  assumes clk is the instruction clock, the core stalls on core_stall,
  and standby/init pins are asynchronous levels from a supervisor.
*/
`include "rsc_defs.svh"

module rsc_ctrl
  import rsc_pkg::*;
#(
  parameter int         WAKE_CYCLES = `RSC_WAKE_CYCLES, // wake wait count
  parameter logic [3:0] P0_RST      = `RSC_NIB_HIGH,    // port zero reset level
  parameter logic [3:0] P1_RST      = `RSC_NIB_HIGH,    // port one reset level
  parameter logic [3:0] P8_RST      = `RSC_NIB_HIGH     // port eight reset level
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // pins from the supervisor and port pins
  input  wire logic        chip_init_input_n,
  input  wire logic        standby_control_pin,
  input  wire logic [2:0]  port_three_in,
  input  wire logic [3:0]  port_one_in,
  input  wire logic [3:0]  port_zero_in,
  // core side
  input  wire logic        standby_instr,
  input  wire rsc_req_t    core_req,
  output logic [3:0]       rd_data,
  output logic             core_reset,
  output logic             core_stall,
  output logic             standby_active,
  output logic             timer0_load,
  output logic             input_mode_reset,
  // port output latches
  output logic [3:0]       port_zero_out,
  output logic [3:0]       port_one_out,
  output logic [2:0]       port_three_out,
  output logic [3:0]       port_eight_out
);

  localparam logic [`RSC_CNT_W-1:0] CNT_LOAD = `RSC_CNT_W'(WAKE_CYCLES - 1);

  // ==========================================================
  // pin synchronisation
  rsc_pins_t  pins_raw;   // raw pin bundle
  rsc_pins_t  pins_s;     // synchronised pin bundle

  assign pins_raw = '{init_n:  chip_init_input_n,
                      standby: standby_control_pin,
                      three:   port_three_in,
                      one:     port_one_in,
                      zero:    port_zero_in};

  rsc_sync2 #(.W(`RSC_PIN_W)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins_s)
  );

  // ==========================================================
  // state registers
  rsc_state_t              state_ff,   nxt_state;   // controller state
  logic [`RSC_CNT_W-1:0]   cnt_ff,     nxt_cnt;     // wake wait count
  logic                    rstc_ff,    nxt_rstc;    // core reset
  logic                    stall_ff,   nxt_stall;   // core stall
  logic                    tload_ff,   nxt_tload;   // timer 0 preset strobe
  logic [3:0]              p0_ff,      nxt_p0;      // port zero latch
  logic [3:0]              p1_ff,      nxt_p1;      // port one latch
  logic [2:0]              p3_ff,      nxt_p3;      // port three latch
  logic [3:0]              p8_ff,      nxt_p8;      // port eight latch
  logic [3:0]              rd_ff,      nxt_rd;      // read data
  logic                    init_req;              // qualified chip init

  // init only counts while the standby pin is high
  assign init_req = !pins_s.init_n && pins_s.standby;

  // ==========================================================
  // next state: sequencing, timer preset, port latches
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rstc  = 1'b0;
    nxt_tload = 1'b0;
    nxt_p0    = p0_ff;
    nxt_p1    = p1_ff;
    nxt_p3    = p3_ff;
    nxt_p8    = p8_ff;
    if (init_req)
    begin
      // chip init: core reset, ports to reset levels, timer preset
      nxt_state = RSC_RUN;
      nxt_rstc  = 1'b1;
      nxt_tload = 1'b1;
      nxt_p0    = P0_RST;
      nxt_p1    = P1_RST;
      nxt_p8    = P8_RST;
      nxt_p3    = `RSC_P3_RESET;
    end
    else
    begin
      unique case (state_ff)
        RSC_RUN:
        begin
          // instruction enters standby only with the pin low
          if (standby_instr && !pins_s.standby)
            nxt_state = RSC_STANDBY;
          else if (core_req.wr)
          begin
            // core write to the selected latch
            unique case (core_req.sel)
              RSC_SEL_ZERO:  nxt_p0 = core_req.data;
              RSC_SEL_ONE:   nxt_p1 = core_req.data;
              RSC_SEL_THREE: nxt_p3 = core_req.data[2:0];
              RSC_SEL_EIGHT: nxt_p8 = core_req.data;
            endcase
          end
        end
        RSC_STANDBY:
        begin
          // pin high clears standby, timer preset, start wait
          if (pins_s.standby)
          begin
            nxt_state = RSC_WAKE;
            nxt_cnt   = CNT_LOAD;
            nxt_tload = 1'b1;
          end
        end
        RSC_WAKE:
        begin
          // hold the core until the count runs out
          if (cnt_ff == '0)
            nxt_state = RSC_RUN;
          else
            nxt_cnt = cnt_ff - 1'b1;
        end
      endcase
    end
    // stall while not running; core state is kept, not reset
    nxt_stall = (nxt_state != RSC_RUN);
  end

  // ==========================================================
  // read mux: latches for output-only port, pins elsewhere
  always_comb
  begin
    nxt_rd = 4'h0;
    unique case (core_req.sel)
      RSC_SEL_ZERO:  nxt_rd = pins_s.zero;
      RSC_SEL_ONE:   nxt_rd = pins_s.one;
      RSC_SEL_THREE: nxt_rd = {pins_s.standby, pins_s.three};
      RSC_SEL_EIGHT: nxt_rd = p8_ff;
    endcase
  end

  // ==========================================================
  // registers; block reset acts as a chip init
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= RSC_RUN;
      cnt_ff   <= '0;
      rstc_ff  <= 1'b1;
      stall_ff <= 1'b0;
      tload_ff <= 1'b1;
      p0_ff    <= P0_RST;
      p1_ff    <= P1_RST;
      p8_ff    <= P8_RST;
      p3_ff    <= `RSC_P3_RESET;
      rd_ff    <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rstc_ff  <= nxt_rstc;
      stall_ff <= nxt_stall;
      tload_ff <= nxt_tload;
      p0_ff    <= nxt_p0;
      p1_ff    <= nxt_p1;
      p3_ff    <= nxt_p3;
      p8_ff    <= nxt_p8;
      rd_ff    <= nxt_rd;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign rd_data          = rd_ff;
  assign core_reset       = rstc_ff;
  assign input_mode_reset = rstc_ff;
  assign core_stall       = stall_ff;
  assign standby_active   = state_ff[1];          // one-hot standby bit, no decode
  assign timer0_load      = tload_ff;
  assign port_zero_out    = p0_ff;
  assign port_one_out     = p1_ff;
  assign port_three_out   = p3_ff;
  assign port_eight_out   = p8_ff;

  // ==========================================================
  // assertions
  property p_stby_entry;
    @(posedge clk) disable iff (rst)
    (state_ff == RSC_RUN) && !init_req && standby_instr && !pins_s.standby
      |=> (state_ff == RSC_STANDBY);
  endproperty
  a_stby_entry: assert property (p_stby_entry)
    else $error("standby not entered on instruction");

  property p_stby_block;
    @(posedge clk) disable iff (rst)
    (state_ff == RSC_RUN) && pins_s.standby |=> (state_ff != RSC_STANDBY);
  endproperty
  a_stby_block: assert property (p_stby_block)
    else $error("standby entered with pin high");

  property p_wake;
    @(posedge clk) disable iff (rst)
    (state_ff == RSC_STANDBY) && pins_s.standby && !init_req
      |=> (state_ff == RSC_WAKE) && (cnt_ff == CNT_LOAD) && timer0_load;
  endproperty
  a_wake: assert property (p_wake)
    else $error("standby not cleared by pin");

  property p_wait_cnt;
    @(posedge clk) disable iff (rst)
    (state_ff == RSC_WAKE) && (cnt_ff != '0) && !init_req
      |=> (state_ff == RSC_WAKE) && (cnt_ff == $past(cnt_ff) - 1'b1);
  endproperty
  a_wait_cnt: assert property (p_wait_cnt)
    else $error("wake wait counted wrongly");

  property p_wait_end;
    @(posedge clk) disable iff (rst)
    (state_ff == RSC_WAKE) && (cnt_ff == '0) && !init_req
      |=> (state_ff == RSC_RUN) && !core_stall;
  endproperty
  a_wait_end: assert property (p_wait_end)
    else $error("core not released at end of wait");

  property p_stall;
    @(posedge clk) disable iff (rst)
    core_stall == (state_ff != RSC_RUN);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall does not follow state");

  property p_init;
    @(posedge clk) disable iff (rst)
    !pins_s.init_n && pins_s.standby |=> core_reset && timer0_load
      && (port_zero_out == P0_RST) && (port_one_out == P1_RST)
      && (port_eight_out == P8_RST) && (port_three_out == `RSC_P3_RESET);
  endproperty
  a_init: assert property (p_init)
    else $error("chip init did not reset core and ports");

  property p_init_ignored;
    @(posedge clk) disable iff (rst)
    !rst && !pins_s.standby |=> !core_reset; // block reset leaves core_reset up one edge
  endproperty
  a_init_ignored: assert property (p_init_ignored)
    else $error("reset taken while standby pin low");

  property p_rd_eight;
    @(posedge clk) disable iff (rst)
    core_req.sel == RSC_SEL_EIGHT |=> rd_data == $past(p8_ff);
  endproperty
  a_rd_eight: assert property (p_rd_eight)
    else $error("port eight read not from latch");

  property p_rd_three;
    @(posedge clk) disable iff (rst)
    core_req.sel == RSC_SEL_THREE |=> rd_data[3] == $past(pins_s.standby);
  endproperty
  a_rd_three: assert property (p_rd_three)
    else $error("standby pin not in port three read");

  c_standby: cover property (@(posedge clk) disable iff (rst)
    state_ff == RSC_STANDBY);
  c_wake_done: cover property (@(posedge clk) disable iff (rst)
    (state_ff == RSC_WAKE) ##1 (state_ff == RSC_RUN));
  c_init: cover property (@(posedge clk) disable iff (rst)
    init_req ##1 core_reset);

endmodule : rsc_ctrl

// File: sim/rsc_supervisor.sv
/*
  supervisor model: drives the standby control pin and the chip init pin.
  assumes the bench asks for pin levels on clk; pins move after an edge.
*/
module rsc_supervisor (
  // clock
  input  wire logic clk,
  // levels asked for by the bench
  input  wire logic sleep_req,
  input  wire logic init_req,
  // pins towards the device
  output logic      standby_control_pin,
  output logic      chip_init_input_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // power-up levels: standby pin high so init stays honoured
  initial
  begin
    standby_control_pin = 1'b1;
    chip_init_input_n   = 1'b1;
  end

  // ==========================================================
  // pins change just after an edge; raising standby wakes the core
  always @(posedge clk)
  begin
    standby_control_pin <= ~sleep_req;
    chip_init_input_n   <= ~init_req;
  end
endmodule : rsc_supervisor

// File: sim/rsc_ctrl_tb.sv
/*
  self-checking bench of rsc_ctrl against a behavioural model.
  assumes rsc_supervisor drives the standby and init pins.
*/
module rsc_ctrl_tb
  import rsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // settings and signals
  localparam int         WK = 8;     // shortened wake wait
  localparam logic [3:0] R0 = 4'hF;  // port zero reset level
  localparam logic [3:0] R1 = 4'h0;  // port one reset level
  localparam logic [3:0] R8 = 4'h0;  // port eight reset level
  logic       clk, rst, slp, ini, sb, in_n, instr;
  logic [2:0] p3i;
  logic [3:0] p0i, p1i, rd, o0, o1, o8;
  logic [2:0] o3;
  logic       crst, stall, sact, tload, imr;
  rsc_req_t   core_req;
  logic [3:0] lat [4];               // model of the output latches
  int         err_count, checks, cyc, n;
  rsc_sel_t   s;
  logic [3:0] d;

  rsc_supervisor rsc_supervisor_i (.clk(clk), .sleep_req(slp), .init_req(ini),
    .standby_control_pin(sb), .chip_init_input_n(in_n));

  rsc_ctrl #(.WAKE_CYCLES(WK), .P0_RST(R0), .P1_RST(R1), .P8_RST(R8)) rsc_ctrl_i (
    .clk(clk), .rst(rst), .chip_init_input_n(in_n), .standby_control_pin(sb),
    .port_three_in(p3i), .port_one_in(p1i), .port_zero_in(p0i),
    .standby_instr(instr), .core_req(core_req), .rd_data(rd), .core_reset(crst),
    .core_stall(stall), .standby_active(sact), .timer0_load(tload),
    .input_mode_reset(imr), .port_zero_out(o0), .port_one_out(o1),
    .port_three_out(o3), .port_eight_out(o8));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic chk(string nm, logic [3:0] exp, logic [3:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // cycle counts, wide enough that a long hang cannot wrap onto the expected value
  task automatic chk_cnt(string nm, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cnt

  // output latches against the model
  task automatic chk_ports();
    chk("port_zero_out", lat[0], o0);
    chk("port_one_out", lat[1], o1);
    chk("port_three_out", lat[2], {1'b0, o3});
    chk("port_eight_out", lat[3], o8);
  endtask : chk_ports

  // one write pulse; sel stays for the read that follows
  task automatic wr_port(rsc_sel_t ws, logic [3:0] wd);
    core_req <= '{wr: 1'b1, sel: ws, data: wd};
    tick(1);
    core_req.wr <= 1'b0;
    tick(1);
  endtask : wr_port

  // read value of a port as the model sees it
  function automatic logic [3:0] exp_rd(rsc_sel_t rs);
    case (rs)
      RSC_SEL_ZERO:  return p0i;
      RSC_SEL_ONE:   return p1i;
      RSC_SEL_THREE: return {sb, p3i};     // standby pin on bit 3
      default:       return lat[3];        // output-only: latch
    endcase
  endfunction : exp_rd

  // wait a bounded time for a flag to reach a level
  task automatic wait_flag(ref logic f, input logic v);
    n = 0;
    while (f !== v && n < 10)
    begin
      tick(1);
      #1;
      n++;
    end
  endtask : wait_flag

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ==========================================================
  // main sequence
  initial
  begin
    {rst, slp, ini, instr} = 4'h8;
    core_req = '0;
    {p0i, p1i, p3i} = '0;
    {err_count, checks, cyc} = '0;
    lat = '{R0, R1, 4'h7, R8};
    void'($urandom(32'h16858ce7));
    // reset: init outputs up, reset levels on the ports
    tick(15);
    #1;
    chk("core_reset", 4'h1, {3'h0, crst});
    chk("timer0_load", 4'h1, {3'h0, tload});
    chk("input_mode_reset", 4'h1, {3'h0, imr});
    tick(1);
    rst <= 1'b0;
    tick(4);
    #1;
    chk_ports();
    $display("reset test done");
    // random writes and reads of every port
    for (int i = 0; i < 24; i++)
    begin
      tick(1);
      s = rsc_sel_t'($urandom_range(3));
      d = 4'($urandom);
      p0i <= 4'($urandom);
      p1i <= 4'($urandom);
      p3i <= 3'($urandom);
      tick(4);
      wr_port(s, d);
      lat[s] = (s == RSC_SEL_THREE) ? {1'b0, d[2:0]} : d;
      tick(2);
      #1;
      chk("rd_data", exp_rd(s), rd);
      chk_ports();
    end
    $display("port test done");
    // init with standby pin high resets ports and timer 0
    tick(1);
    ini <= 1'b1;
    wait_flag(crst, 1'b1);
    lat = '{R0, R1, 4'h7, R8};
    chk("core_reset", 4'h1, {3'h0, crst});
    chk("timer0_load", 4'h1, {3'h0, tload});
    chk_ports();
    chk("input_mode_reset", 4'h1, {3'h0, imr});
    tick(1);
    ini <= 1'b0;
    tick(5);
    // standby instruction refused while the pin is high
    instr <= 1'b1;
    tick(1);
    instr <= 1'b0;
    tick(3);
    #1;
    chk("standby_active", 4'h0, {3'h0, sact});
    $display("init test done");
    // init refused while the standby pin is low
    tick(1);
    wr_port(RSC_SEL_EIGHT, ~R8);
    lat[3] = ~R8;
    slp <= 1'b1;
    tick(4);
    ini <= 1'b1;
    tick(8);
    #1;
    chk("core_reset", 4'h0, {3'h0, crst});
    chk_ports();
    tick(1);
    ini <= 1'b0;
    core_req.sel <= RSC_SEL_THREE;
    tick(5);
    // standby entry, ignored write, wake and wait count
    instr <= 1'b1;
    tick(1);
    instr <= 1'b0;
    tick(1);
    #1;
    chk("standby_active", 4'h1, {3'h0, sact});
    chk("core_stall", 4'h1, {3'h0, stall});
    chk("rd_data", exp_rd(RSC_SEL_THREE), rd);
    tick(1);
    wr_port(RSC_SEL_ZERO, ~lat[0]);
    tick(1);
    #1;
    chk_ports();
    tick(1);
    slp <= 1'b0;
    wait_flag(sact, 1'b0);
    chk("timer0_load", 4'h1, {3'h0, tload});
    n = 0;
    while (stall === 1'b1 && n < 100)
    begin
      n++;
      tick(1);
      #1;
    end
    chk_cnt("wake_cycles", 16'(WK), 16'(n));
    $display("standby test done");
    final_report();
  end
endmodule : rsc_ctrl_tb
